// ---- hdl/csvs_pkg.sv ----
// package: constants and types for the card supply voltage select block
package csvs_pkg;

    // =====================================================================
    // timing figures, in their own units
    localparam int unsigned CLK_MHZ          = 250;
    localparam int unsigned LONG_HIGH_MS     = 30;
    localparam int unsigned SHORT_HIGH_MS    = 15;
    localparam int unsigned PULSE_MIN_US     = 200;
    localparam int unsigned LOW_MAX_US       = 700;

    // =====================================================================
    // derived cycle counts (least times round up, longest round down)
    localparam longint unsigned LONG_HIGH_CYC  = longint'(LONG_HIGH_MS) * 1000 * CLK_MHZ;
    localparam longint unsigned SHORT_HIGH_CYC = longint'(SHORT_HIGH_MS) * 1000 * CLK_MHZ;
    localparam longint unsigned PULSE_MIN_CYC  = longint'(PULSE_MIN_US) * CLK_MHZ;
    localparam longint unsigned LOW_MAX_CYC    = longint'(LOW_MAX_US) * CLK_MHZ;
    localparam int unsigned     CNT_W          = 24;

    // =====================================================================
    // supply level encoding and reset value
    typedef enum logic [0:0] {
        CSVS_VCC_3V = 1'b0,
        CSVS_VCC_5V = 1'b1
    } csvs_vcc_t;
    localparam csvs_vcc_t VCC_RESET = CSVS_VCC_3V;

    // selector states, gray along idle -> low -> high -> active
    typedef enum logic [1:0] {
        CSVS_IDLE   = 2'b00,
        CSVS_SEL_LO = 2'b01,
        CSVS_SEL_HI = 2'b11,
        CSVS_ACTIVE = 2'b10
    } csvs_state_t;

    // outputs toward the activation and deactivation sequencers
    typedef struct packed {
        logic      activate;   // one-cycle pulse on activation command
        logic      deactivate; // one-cycle pulse on session end, except one ending an in-window low after 5 V
        logic      session;    // level, card session running
        csvs_vcc_t vcc_sel;    // chosen supply level
        logic      sel_valid;  // choice came from a documented timing
    } csvs_ctrl_t;

endpackage

// ---- hdl/csvs_select.sv ----
// module: card supply voltage selection from request pin timing
// Notes on behaviour
// - time request HIGH before fall, pick supply
// - HIGH over 30 ms selects 5 V
// - HIGH under 15 ms selects 3 V
// - after long idle, pulse pattern selects 3 V
// - falling edge is activation command, except a fall from idle after a HIGH between 15 and 30 ms
// - rising edge ends session, starts deactivation unless it ends an in-window low after a 5 V activation
module csvs_select
#(
    parameter longint unsigned LONG_CYC  = csvs_pkg::LONG_HIGH_CYC,
    parameter longint unsigned SHORT_CYC = csvs_pkg::SHORT_HIGH_CYC,
    parameter longint unsigned PMIN_CYC  = csvs_pkg::PULSE_MIN_CYC,
    parameter longint unsigned LMAX_CYC  = csvs_pkg::LOW_MAX_CYC
)
(
    // clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 rstn_i,
    // request pin from host, active low
    input  wire logic                 card_power_request_n_i,
    // controls to the sequencers
    output csvs_pkg::csvs_ctrl_t      ctrl_o
);
    import csvs_pkg::*;

    // =====================================================================
    // how the choice is made
    // the phase timer counts cycles since the last pin edge, so at a fall
    // it holds the high time and at a rise it holds the low time.
    // a fall after a long high activates at 5 V at once: the pin gives no
    // way to tell a 5 V request from the first low of the 3 V pattern.
    // a 3 V card is therefore briefly offered a 5 V activation; if the pin
    // rises again inside the low window, that session end is kept from
    // the deactivation sequencer and the next fall reselects 3 V.
    // a fall after a high in the refused span starts the pattern instead
    // and gives no activation until the final fall of the pattern.
    // pulses outside their windows still end in a 3 V activation, but
    // sel_valid is low so the sequencers can refuse the choice.
    // the timer saturates, so an idle pin of any length reads as long.

    // window limits in cycles, cut to the timer width
    localparam logic [CNT_W-1:0] LONG_C  = CNT_W'(LONG_CYC);
    localparam logic [CNT_W-1:0] SHORT_C = CNT_W'(SHORT_CYC);
    localparam logic [CNT_W-1:0] SHORT_L = SHORT_C - 1'b1;      // last short-high count
    localparam logic [CNT_W-1:0] PMIN_C  = CNT_W'(PMIN_CYC);
    localparam logic [CNT_W-1:0] LMAX_C  = CNT_W'(LMAX_CYC);
    localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};

    // =====================================================================
    // edge detection on the request pin
    logic        req_n_d_r;
    logic        fall;
    logic        rise;

    // previous pin sample, idle high so reset gives no false edge
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            req_n_d_r <= 1'b1;
        else
            req_n_d_r <= card_power_request_n_i;
    end

    // one-cycle edge strobes
    assign fall = req_n_d_r & ~card_power_request_n_i;
    assign rise = ~req_n_d_r & card_power_request_n_i;

    // =====================================================================
    // phase timer, restarted on every edge, saturating
    logic [CNT_W-1:0] cnt_r;
    logic             long_high;
    logic             mid_high;

    // cycles since the last edge
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            cnt_r <= '0;
        else if (rise || fall)
            cnt_r <= '0;
        else if (cnt_r != CNT_MAX)
            cnt_r <= cnt_r + 1'b1;
    end

    // elapsed high time less the edge cycle, which the timer does not count
    assign long_high = (cnt_r >= LONG_C);
    assign mid_high  = (cnt_r >= SHORT_C) && !long_high;

    // =====================================================================
    // selector state machine
    csvs_state_t state_r;
    csvs_vcc_t   vcc_r;
    logic        valid_r;
    logic        act_r;
    logic        deact_r;
    logic        pend_r;
    logic        in_low_ok;
    logic        in_high_ok;
    logic        take_idle;
    logic        take_pat;

    // timer position inside a pulse window, ends included
    function automatic logic in_window(input logic [CNT_W-1:0] cnt,
                                       input logic [CNT_W-1:0] lo,
                                       input logic [CNT_W-1:0] hi);
        in_window = (cnt >= lo) && (cnt <= hi);
    endfunction

    // low and high phases of the 3 V pattern
    assign in_low_ok  = in_window(cnt_r, PMIN_C, LMAX_C);
    assign in_high_ok = in_window(cnt_r, PMIN_C, SHORT_L);

    // activation commands: a fall from idle outside the refused span, or the pattern end
    assign take_idle = (state_r == CSVS_IDLE) && fall && !mid_high;
    assign take_pat  = (state_r == CSVS_SEL_HI) && fall;

    // phase of the selection
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            state_r <= CSVS_IDLE;
        else
        begin
            case (state_r)
                CSVS_IDLE:
                begin
                    if (fall && mid_high)
                        state_r <= CSVS_SEL_LO;
                    else if (fall)
                        state_r <= CSVS_ACTIVE;
                end
                CSVS_SEL_LO:
                begin
                    if (rise)
                        state_r <= CSVS_SEL_HI;
                end
                CSVS_SEL_HI:
                begin
                    if (fall)
                        state_r <= CSVS_ACTIVE;
                end
                CSVS_ACTIVE:
                begin
                    if (rise)
                        state_r <= CSVS_IDLE;
                end
                default:
                    state_r <= CSVS_IDLE;
            endcase
        end
    end

    // supply level, changed only together with an activation pulse
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            vcc_r <= VCC_RESET;
        else if (take_idle && long_high)
            vcc_r <= CSVS_VCC_5V;
        else if (take_idle || take_pat)
            vcc_r <= CSVS_VCC_3V;
    end

    // validity of the choice; phases outside their windows mark it undefined
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            valid_r <= 1'b0;
        else if (take_idle)
            valid_r <= 1'b1;
        else if (state_r == CSVS_IDLE && fall)
            valid_r <= 1'b0;
        else if (state_r == CSVS_SEL_LO && rise)
            valid_r <= in_low_ok;
        else if (take_pat)
            valid_r <= valid_r && in_high_ok;
    end

    // activation pulse, one cycle after the accepted fall
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            act_r <= 1'b0;
        else
            act_r <= take_idle || take_pat;
    end

    // session end pulse; pend_r is read before the rise clears it
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            deact_r <= 1'b0;
        else
            deact_r <= (state_r == CSVS_ACTIVE) && rise && !(pend_r && in_low_ok);
    end

    // =====================================================================
    // a long-idle fall might be the low of the 3 V pattern; if the pin
    // rises again within the low window it is treated as that pattern
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            pend_r <= 1'b0;
        else if (take_idle && long_high)
            pend_r <= 1'b1;
        else if (rise || (pend_r && cnt_r > LMAX_C))
            pend_r <= 1'b0;
    end

    // =====================================================================
    // output assembly
    always_comb
    begin
        ctrl_o.activate   = act_r;
        ctrl_o.deactivate = deact_r;
        ctrl_o.session    = (state_r == CSVS_ACTIVE);
        ctrl_o.vcc_sel    = vcc_r;
        ctrl_o.sel_valid  = valid_r;
    end

endmodule

// ---- tb/card_supply_voltage_select_tb.sv ----
// testbench: supply select against a behavioural model
module card_supply_voltage_select_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import csvs_pkg::*;
    localparam int LC = 300, SC = 150, PMIN = 20, LMAX = 70;
    logic        clk_i = 1'b0;
    logic        rstn_i = 1'b0;
    logic        req_n;
    csvs_ctrl_t  ctrl;
    int          err_count = 0, n_tests = 0, n_deact = 0, exp_deact = 0;
    logic [15:0] lfsr = 16'hFB8F;
    logic [1:0]  got_q[$];
    // next state of the stimulus shift register
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    always #2 clk_i = ~clk_i;
    csvs_select #(.LONG_CYC(LC), .SHORT_CYC(SC), .PMIN_CYC(PMIN), .LMAX_CYC(LMAX))
        csvs_select_inst (.clk_i(clk_i), .rstn_i(rstn_i), .card_power_request_n_i(req_n),
        .ctrl_o(ctrl));
    csvs_host_model csvs_host_model_inst (.clk_i(clk_i), .req_n_o(req_n));
    // collect activations and session ends
    always @(posedge clk_i)
    begin
        if (ctrl.activate === 1'b1) got_q.push_back({ctrl.sel_valid, ctrl.vcc_sel});
        if (ctrl.deactivate === 1'b1) n_deact++;
    end
    task automatic conclude();
        if (err_count == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // act: 0 none, 1 at 3 V, 2 at 5 V
    task automatic chk_act(input int act);
        logic [1:0] first;
        n_tests++;
        first = (got_q.size() > 0) ? got_q[0] : 2'b00;
        if (got_q.size() != int'(act != 0) || (act != 0 && first !== {1'b1, act == 2}))
        begin
            err_count++;
            $display("[FAIL] activation expected count %0d word %b seen count %0d word %b",
                int'(act != 0), {1'b1, act == 2}, got_q.size(), first);
        end
        got_q.delete();
    endtask
    task automatic chk_cnt(input int exp, input int got);
        n_tests++;
        if (exp != got)
        begin
            err_count++;
            $display("[FAIL] deactivations expected %0d seen %0d", exp, got);
        end
    endtask
    // model: high span decides, a window low pulse after 5 V hides the session end
    task automatic step(input int hi, input int lo);
        int act;
        act = (hi >= LC + 2) ? 2 : (hi < SC - 2) ? 1 : 0;
        csvs_host_model_inst.phase(1'b1, hi);
        csvs_host_model_inst.phase(1'b0, lo);
        chk_act(act);
        if (act != 0 && !(act == 2 && lo > PMIN + 2 && lo < LMAX - 2)) exp_deact++;
    endtask
    initial
    begin
        #(4 * 20000);
        err_count++;
        conclude();
    end
    initial
    begin
        repeat (12) @(posedge clk_i);
        #1 rstn_i = 1'b1;
        step(320, 100);
        step(50, 100);
        step(200, 40);
        step(50, 100);
        step(320, 40);
        step(50, 100);
        repeat (8)
        begin
            lfsr = lfsr_next(lfsr);
            step(lfsr[0] ? 310 + lfsr[7:1] : 10 + lfsr[7:1], 80 + lfsr[11:8]);
        end
        csvs_host_model_inst.phase(1'b1, 10);
        chk_cnt(exp_deact, n_deact);
        conclude();
    end
endmodule

// ---- tb/csvs_host_model.sv ----
// host model: drives the active-low card power request pin
module csvs_host_model
(
    // clock and request pin
    input  wire logic clk_i,
    output logic      req_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial req_n_o = 1'b1;
    // hold a level for n samples: high span picks the supply, low span forms the pattern
    task automatic phase(input logic lvl, input int n);
        @(posedge clk_i);
        #1 req_n_o = lvl;
        repeat (n - 1) @(posedge clk_i);
    endtask
endmodule

// ---- tb/csvs_select_monitor.sv ----
// checker: timing relations at the supply select ports
module csvs_select_monitor
#(
    parameter longint unsigned LONG_CYC  = 300,
    parameter longint unsigned SHORT_CYC = 150
)
(
    // clock, reset, pin and controls
    input wire logic                 clk_i,
    input wire logic                 rstn_i,
    input wire logic                 card_power_request_n_i,
    input wire csvs_pkg::csvs_ctrl_t ctrl_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import csvs_pkg::*;
    wire logic       pin = card_power_request_n_i;
    longint unsigned run_r;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    // ==========================================
    // high run length, cleared by a low sample
    always_ff @(posedge clk_i or negedge rstn_i)
        if (!rstn_i) run_r <= 0;
        else run_r <= pin ? run_r + 1 : 0;
    // ==========================================
    // checks
    a_act_on_fall: assert property (ctrl_o.activate |-> !$past(pin) && $past(pin, 2))
        else $error("activate without fall");
    a_session_starts: assert property (ctrl_o.activate |-> ctrl_o.session)
        else $error("no session on activate");
    a_deact_on_rise: assert property (ctrl_o.deactivate |-> $past(pin) && !$past(pin, 2))
        else $error("deactivate without rise");
    a_session_ends: assert property (ctrl_o.session && pin |=> !ctrl_o.session)
        else $error("session kept after rise");
    a_vcc_held: assert property ($changed(ctrl_o.vcc_sel) |-> ctrl_o.activate)
        else $error("supply changed without activate");
    a_long_high_5v: assert property ($fell(pin) && run_r >= LONG_CYC + 2 |=>
        ctrl_o.activate && ctrl_o.vcc_sel == CSVS_VCC_5V) else $error("long high not 5V");
    a_short_high_3v: assert property ($fell(pin) && run_r < SHORT_CYC - 2 |=>
        ctrl_o.activate && ctrl_o.vcc_sel == CSVS_VCC_3V) else $error("short high not 3V");
    a_mid_refused: assert property ($fell(pin) && run_r >= SHORT_CYC + 2 &&
        run_r < LONG_CYC - 2 |=> !ctrl_o.activate) else $error("mid high activated");
endmodule
bind csvs_select csvs_select_monitor #(.LONG_CYC(LONG_CYC), .SHORT_CYC(SHORT_CYC)) mon_inst (
    .clk_i(clk_i), .rstn_i(rstn_i), .card_power_request_n_i(card_power_request_n_i),
    .ctrl_o(ctrl_o));
